// ===== shared/lcc_pkg.sv
// Purpose: constants for the link cycle control and interrupt register block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   control and diagnostics offsets are local choices
package lcc_pkg;
    localparam logic [7:0]  LCC_OFS_CTRL      = 8'h08;
    localparam logic [7:0]  LCC_OFS_IRQ_STAT  = 8'h0c;
    localparam logic [7:0]  LCC_OFS_IRQ_MASK  = 8'h10;
    localparam logic [7:0]  LCC_OFS_DIAG      = 8'h20;
    localparam logic [7:0]  LCC_OFS_CYC_TIMER = 8'h14;
    localparam logic [7:0]  LCC_OFS_ISO_CHAN  = 8'h18;
    localparam logic [7:0]  LCC_OFS_STATUS    = 8'h1c;
    // control field positions
    localparam int          LCC_CTL_MASTER    = 20;
    localparam int          LCC_CTL_EXT_SRC   = 21;
    localparam int          LCC_CTL_TMR_RUN   = 22;
    localparam int          LCC_CTL_CYMRK     = 23;
    localparam int          LCC_CTL_IRP1      = 24;
    localparam int          LCC_CTL_IRP2      = 25;
    localparam int          LCC_CTL_XOUT      = 31;
    localparam logic [31:0] LCC_CTL_WMASK     = 32'h83f0_0000;
    localparam logic [31:0] LCC_CTL_RESET     = 32'h0000_0000;
    // interrupt
    localparam int          LCC_IRQ_SUM       = 0;
    localparam int          LCC_IRQ_PHY       = 1;
    localparam logic [31:0] LCC_IRQ_RESET     = 32'h0100_0000;
    localparam logic [31:0] LCC_MASK_RESET    = 32'h0000_0000;
    localparam int          LCC_DIAG_ACCESS   = 0;
    // cycle timer: 3072 offset ticks per cycle at 24.576 MHz nominal
    localparam logic [11:0] LCC_OFFSET_LAST   = 12'hbff;
    localparam logic [31:0] LCC_UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ===== src/lcc_regs.sv
// Purpose: control fields, cycle timer core and interrupt registers
// Assumes: one clock, synchronous active-high reset, classic wishbone
// Notes:   ack one cycle after request, dropped for one cycle after
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module lcc_regs
    import lcc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // link status
    input  wire logic        phy_is_root_i,
    input  wire logic        external_cycle_input_i,
    input  wire logic        iso_cycle_end_i,
    input  wire logic        iso_rx_valid_i,
    input  wire logic [5:0]  iso_rx_channel_i,
    input  wire logic [31:0] irq_events_i,
    input  wire logic        phy_irq_i,
    // receive fifo and transmitter
    input  wire logic        fifo_empty_i,
    input  wire logic        cycle_done_i,
    output logic             cycle_mark_insert_o,
    output logic             cycle_start_send_o,
    output logic             iso_rx_accept_o,
    output logic             cycle_master_active_o,
    // extended pins, three-state
    output logic             rx_fifo_empty_out_o,
    output logic             cycle_done_out_o,
    output logic             cycle_start_out_o,
    output logic             ext_out_oe_o,
    // host interrupt
    output logic             host_irq_o
);
    // registers
    logic [31:0] link_control_r;
    logic [31:0] interrupt_status_r;
    logic [31:0] interrupt_status_nxt;
    logic [31:0] interrupt_mask_r;
    logic        access_mode_r;
    logic [5:0]  chan_one_r;
    logic [5:0]  chan_two_r;
    logic [11:0] offset_r;
    logic [11:0] offset_nxt;
    logic [12:0] count_r;
    logic [12:0] count_nxt;
    logic        cycin_d_r;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic        cstart_r;
    logic        cmark_r;
    logic        accept_r;
    // decoded bus terms
    logic        req;
    logic        wr;
    logic        rd;
    logic [31:0] wmask;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_mask;
    logic        wr_diag;
    logic        wr_chan;
    // control fields
    logic        cycle_master_enable;
    logic        external_cycle_source_select;
    logic        cycle_timer_run;
    logic        cycle_marker_insert_enable;
    logic        iso_rx_port_one_enable;
    logic        iso_rx_port_two_enable;
    logic        extended_output_enable;
    // timer and interrupt terms
    logic        cyc_rise;
    logic        offset_wrap;
    logic        bump;
    logic        summary;
    logic        chan_one_hit;
    logic        chan_two_hit;

    // byte enables to bit mask, used for control, mask and status writes
    function automatic logic [31:0] lanes(input logic [3:0] s);
        lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // merge write data into a register under lane and field masks
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [31:0] m);
        merge = (old & ~m) | (d & m);
    endfunction

    // one address compare, shared by every write strobe
    function automatic logic is_at(input logic [7:0] a,
                                   input logic [7:0] ofs);
        is_at = (a == ofs);
    endfunction

    // ack blocks a second take of the same held request
    assign req     = cyc_i && stb_i && !ack_r;
    assign wr      = req && we_i;
    assign rd      = req && !we_i;
    assign wmask   = lanes(sel_i);
    assign wr_ctrl = wr && is_at(adr_i, LCC_OFS_CTRL);
    assign wr_stat = wr && is_at(adr_i, LCC_OFS_IRQ_STAT);
    assign wr_mask = wr && is_at(adr_i, LCC_OFS_IRQ_MASK);
    assign wr_diag = wr && is_at(adr_i, LCC_OFS_DIAG);
    assign wr_chan = wr && is_at(adr_i, LCC_OFS_ISO_CHAN);
    assign ack_o   = ack_r;
    assign dat_o   = rdat_r;

    // control field taps
    assign cycle_master_enable          = link_control_r[LCC_CTL_MASTER];
    assign external_cycle_source_select = link_control_r[LCC_CTL_EXT_SRC];
    assign cycle_timer_run              = link_control_r[LCC_CTL_TMR_RUN];
    assign cycle_marker_insert_enable   = link_control_r[LCC_CTL_CYMRK];
    assign iso_rx_port_one_enable       = link_control_r[LCC_CTL_IRP1];
    assign iso_rx_port_two_enable       = link_control_r[LCC_CTL_IRP2];
    assign extended_output_enable       = link_control_r[LCC_CTL_XOUT];

    // wishbone ack: one cycle, dropped after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_r <= 32'h0000_0000;
        else if (rd)
        begin
            unique case (adr_i)
                LCC_OFS_CTRL:      rdat_r <= link_control_r & LCC_CTL_WMASK;
                LCC_OFS_IRQ_STAT:  rdat_r <= {interrupt_status_r[31:1], summary};
                LCC_OFS_IRQ_MASK:  rdat_r <= interrupt_mask_r;
                LCC_OFS_DIAG:      rdat_r <= {31'h0000_0000, access_mode_r};
                LCC_OFS_CYC_TIMER: rdat_r <= {7'h00, count_r, offset_r};
                LCC_OFS_ISO_CHAN:  rdat_r <= {18'h0_0000, chan_two_r, 2'h0, chan_one_r};
                LCC_OFS_STATUS:    rdat_r <= {31'h0000_0000, cycle_master_active_o};
                default:           rdat_r <= LCC_UNMAPPED_DATA;
            endcase
        end
    end

    // no bus reset term: only power-on reset clears
    // limitation: software alone moves the master bit after a bus reset
    // extended output bit zero at reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            link_control_r <= LCC_CTL_RESET;
        else if (wr_ctrl)
            link_control_r <= merge(link_control_r, dat_i, wmask & LCC_CTL_WMASK);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            interrupt_mask_r <= LCC_MASK_RESET;
        else if (wr_mask)
            interrupt_mask_r <= merge(interrupt_mask_r, dat_i, wmask);
    end

    // access mode for the interrupt bits, lane zero only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            access_mode_r <= 1'b0;
        else if (wr_diag && sel_i[0])
            access_mode_r <= dat_i[LCC_DIAG_ACCESS];
    end

    // channel one, lane zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            chan_one_r <= 6'h00;
        else if (wr_chan && sel_i[0])
            chan_one_r <= dat_i[5:0];
    end

    // channel two, lane one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            chan_two_r <= 6'h00;
        else if (wr_chan && sel_i[1])
            chan_two_r <= dat_i[13:8];
    end

    // interrupt bits; event set wins over a clear in the same cycle
    always_comb
    begin
        interrupt_status_nxt = interrupt_status_r;
        if (wr_stat)
        begin
            if (access_mode_r)
                interrupt_status_nxt = merge(interrupt_status_r, dat_i, wmask);
            else
                interrupt_status_nxt = interrupt_status_r
                                     & ~(dat_i & wmask & 32'hffff_fffe);
        end
        interrupt_status_nxt = interrupt_status_nxt | (irq_events_i & 32'hffff_fffc);
        interrupt_status_nxt[LCC_IRQ_PHY] = interrupt_status_nxt[LCC_IRQ_PHY] | phy_irq_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            interrupt_status_r <= LCC_IRQ_RESET;
        else
            interrupt_status_r <= interrupt_status_nxt;
    end

    // summary is stored bit 0 or'd with masked bits 1..31
    // recomputed every cycle, cannot stay cleared
    assign summary = interrupt_status_r[LCC_IRQ_SUM]
                   | (|(interrupt_status_r[31:1] & interrupt_mask_r[31:1]));
    // host interrupt gated by summary mask
    assign host_irq_o = summary & interrupt_mask_r[LCC_IRQ_SUM];

    assign cycle_master_active_o = cycle_master_enable & phy_is_root_i;

    // edge of external cycle input
    // cleared low at reset, so an input already high when reset ends counts as an edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cycin_d_r <= 1'b0;
        else
            cycin_d_r <= external_cycle_input_i;
    end
    assign cyc_rise = external_cycle_input_i & ~cycin_d_r;

    assign offset_wrap = cycle_timer_run && offset_r == LCC_OFFSET_LAST;
    assign bump = external_cycle_source_select ? cyc_rise : offset_wrap;

    always_comb
    begin
        offset_nxt = offset_r;
        count_nxt  = count_r;
        if (external_cycle_source_select && cyc_rise)
            offset_nxt = 12'h000;
        // offset runs only with run bit
        else if (cycle_timer_run)
            offset_nxt = offset_wrap ? 12'h000 : offset_r + 12'h001;
        if (bump)
            count_nxt = count_r + 13'h0001;
    end

    // count and offset step together, one register pair
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            offset_r <= 12'h000;
            count_r  <= 13'h0000;
        end
        else
        begin
            offset_r <= offset_nxt;
            count_r  <= count_nxt;
        end
    end

    // cycle start on count increment while master
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cstart_r <= 1'b0;
        else
            cstart_r <= bump & cycle_master_active_o;
    end
    assign cycle_start_send_o = cstart_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cmark_r <= 1'b0;
        else
            cmark_r <= iso_cycle_end_i & cycle_marker_insert_enable;
    end
    assign cycle_mark_insert_o = cmark_r;

    assign chan_one_hit = iso_rx_port_one_enable && iso_rx_channel_i == chan_one_r;
    assign chan_two_hit = iso_rx_port_two_enable && iso_rx_channel_i == chan_two_r;

    // registered, so the accept lags the packet by one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            accept_r <= 1'b0;
        else
            accept_r <= iso_rx_valid_i && (chan_one_hit || chan_two_hit);
    end
    assign iso_rx_accept_o = accept_r;

    // pin values always pass through; only the enable follows the extended output bit
    assign ext_out_oe_o        = extended_output_enable;
    assign rx_fifo_empty_out_o = fifo_empty_i;
    assign cycle_done_out_o    = cycle_done_i;
    assign cycle_start_out_o   = cstart_r;
endmodule
`default_nettype wire

// ===== verification/lcc_host_model.sv
// Purpose: host processor model, classic wishbone master
// Assumes: slave gives read data together with ack
// Notes:   waits without limit, the bench watchdog cuts hangs
`timescale 1ns/100ps
`default_nettype none
module lcc_host_model (
    // clock
    input  wire logic        clk_i,
    // wishbone master
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    // one classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hf, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        {cyc_o, stb_o, we_o} <= 3'b000;
    endtask
endmodule
`default_nettype wire

// ===== verification/lcc_regs_chk.sv
// Purpose: port level checks on lcc_regs
// Assumes: one clock, rst_i synchronous active high
// Notes:   control bits are hidden, so pulses are tied to causes
`timescale 1ns/100ps
`default_nettype none
module lcc_regs_chk
    import lcc_pkg::*;
(
    // clock, reset, wishbone
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       we_i,
    input wire logic [7:0] adr_i,
    input wire logic       ack_o,
    // link side
    input wire logic       phy_is_root_i,
    input wire logic       iso_cycle_end_i,
    input wire logic       iso_rx_valid_i,
    input wire logic       cycle_mark_insert_o,
    input wire logic       cycle_start_send_o,
    input wire logic       cycle_start_out_o,
    input wire logic       iso_rx_accept_o,
    input wire logic       cycle_master_active_o,
    input wire logic       ext_out_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    sequence s_ans; ack_o ##1 !ack_o; endsequence
    property p_ack; s_req |=> s_ans; endproperty
    a_ack: assert property (p_ack) else $error("request not acked once");
    property p_root; cycle_master_active_o |-> phy_is_root_i; endproperty
    a_root: assert property (p_root) else $error("master active off root");
    property p_start; cycle_start_send_o |-> $past(cycle_master_active_o); endproperty
    a_start: assert property (p_start) else $error("cycle start while not master");
    property p_pin; cycle_start_out_o == cycle_start_send_o; endproperty
    a_pin: assert property (p_pin) else $error("cycle start pin differs");
    property p_mark; cycle_mark_insert_o |-> $past(iso_cycle_end_i); endproperty
    a_mark: assert property (p_mark) else $error("mark without cycle end");
    property p_acc; iso_rx_accept_o |-> $past(iso_rx_valid_i); endproperty
    a_acc: assert property (p_acc) else $error("accept without packet");
    property p_oe0; $fell(rst_i) |-> !ext_out_oe_o; endproperty
    a_oe0: assert property (p_oe0) else $error("extended pins on after reset");
    // bus reset never drops master active, only power-on reset, software or root loss
    property p_keep; $fell(cycle_master_active_o) |-> $past(rst_i) || !phy_is_root_i
        || $past(cyc_i && stb_i && we_i && adr_i == LCC_OFS_CTRL); endproperty
    a_keep: assert property (p_keep) else $error("master bit lost");
endmodule
bind lcc_regs lcc_regs_chk lcc_regs_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .ack_o, .phy_is_root_i, .iso_cycle_end_i, .iso_rx_valid_i, .cycle_mark_insert_o,
    .cycle_start_send_o, .cycle_start_out_o, .iso_rx_accept_o, .cycle_master_active_o,
    .ext_out_oe_o);
`default_nettype wire

// ===== verification/lcc_regs_test.sv
// Purpose: self-checking bench for lcc_regs
// Assumes: host model speaks classic wishbone
// Notes:   one offset roll takes 3072 cycles
`timescale 1ns/100ps
`default_nettype none
module lcc_regs_test
    import lcc_pkg::*;
;
    logic        clk_i = 0;
    logic        rst_i = 1;
    logic        root = 0, xcyc = 0, cyend = 0, vld = 0, phyirq = 0;
    logic [5:0]  chan = 0;
    logic [31:0] ev = 0, q;
    int          bad_count = 0, samples_checked = 0, starts = 0, n0;
    wire logic   cyc, stb, we, ack, irq, oe, mark, acc, sst, act, fe, cdo;
    wire logic [7:0]  adr;
    wire logic [3:0]  sel;
    wire logic [31:0] wd, rdat;
    // ctrl value, channel, expected {mark, accept}
    logic [31:0] rows [5][3] = '{'{32'h0180_0000, 5, 3}, '{32'h0200_0000, 5, 0},
        '{32'h0200_0000, 9, 1}, '{32'h0100_0000, 9, 0}, '{32'h0080_0000, 1, 2}};
    lcc_host_model lcc_host_model_i (.clk_i, .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wd), .dat_i(rdat), .ack_i(ack));
    lcc_regs lcc_regs_i (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack), .phy_is_root_i(root),
        .external_cycle_input_i(xcyc), .iso_cycle_end_i(cyend), .iso_rx_valid_i(vld),
        .iso_rx_channel_i(chan), .irq_events_i(ev), .phy_irq_i(phyirq),
        .fifo_empty_i(1'b1), .cycle_done_i(1'b1), .cycle_mark_insert_o(mark),
        .cycle_start_send_o(sst), .iso_rx_accept_o(acc), .cycle_master_active_o(act),
        .rx_fifo_empty_out_o(fe), .cycle_done_out_o(cdo), .cycle_start_out_o(),
        .ext_out_oe_o(oe), .host_irq_o(irq));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) starts <= starts + sst;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
            $display("[ERR] %s expected %h seen %h", n, e, g);
        bad_count += (g !== e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        lcc_host_model_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        lcc_host_model_i.xfer(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    task automatic pulse_chk(input logic [31:0] e);
        @(posedge clk_i);
        {cyend, vld} <= 2'b11;
        @(posedge clk_i);
        {cyend, vld} <= 2'b00;
        @(negedge clk_i);
        chk("mark_acc", e, {30'h0, mark, acc});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #200_000;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        rc(LCC_OFS_CTRL, 32'h0, "ctrl_rst");
        rc(LCC_OFS_IRQ_MASK, 32'h0, "mask_rst");
        rc(LCC_OFS_IRQ_STAT, 32'h0100_0000, "irq_rst");
        wr(LCC_OFS_ISO_CHAN, 32'h0000_0905);
        foreach (rows[i])
        begin
            wr(LCC_OFS_CTRL, rows[i][0]);
            chan <= rows[i][1][5:0];
            pulse_chk(rows[i][2]);
        end
        $display("test iso ports and marks done");
        wr(LCC_OFS_CTRL, 32'hffff_ffff);
        rc(LCC_OFS_CTRL, LCC_CTL_WMASK, "ctrl_rsvd");
        chk("pins_oe", 1, {31'h0, oe & fe});
        chk("done_pin", 1, {31'h0, cdo});
        chk("act_nonroot", 0, {31'h0, act});
        @(posedge clk_i) root <= 1;
        @(negedge clk_i) chk("act_root", 1, {31'h0, act});
        // software on a node no longer root clears the master bit
        @(posedge clk_i) root <= 0;
        wr(LCC_OFS_CTRL, 32'h0);
        wr(LCC_OFS_IRQ_MASK, 32'ha5a5_5a5a);
        rc(LCC_OFS_IRQ_MASK, 32'ha5a5_5a5a, "mask_rw");
        wr(8'h04, 32'hffff_ffff);
        rc(8'h04, LCC_UNMAPPED_DATA, "unmapped");
        $display("test register access done");
        wr(LCC_OFS_IRQ_MASK, 32'h0);
        wr(LCC_OFS_IRQ_STAT, 32'hffff_ffff);
        rc(LCC_OFS_IRQ_STAT, 32'h0, "irq_w1c");
        @(posedge clk_i) {phyirq, ev} <= {1'b1, 32'h0000_0020};
        @(posedge clk_i) {phyirq, ev} <= '0;
        rc(LCC_OFS_IRQ_STAT, 32'h0000_0022, "irq_set");
        chk("irq_masked", 0, {31'h0, irq});
        wr(LCC_OFS_IRQ_MASK, 32'h0000_0003);
        rc(LCC_OFS_IRQ_STAT, 32'h0000_0023, "irq_sum");
        chk("irq_on", 1, {31'h0, irq});
        wr(LCC_OFS_IRQ_STAT, 32'h0000_0021);
        rc(LCC_OFS_IRQ_STAT, 32'h0000_0003, "sum_stays");
        wr(LCC_OFS_IRQ_STAT, 32'h0000_0002);
        rc(LCC_OFS_IRQ_STAT, 32'h0, "sum_gone");
        wr(LCC_OFS_DIAG, 32'h0000_0001);
        wr(LCC_OFS_IRQ_STAT, 32'h0000_0005);
        rc(LCC_OFS_IRQ_STAT, 32'h0000_0005, "irq_plain_rw");
        chk("irq_rw_on", 1, {31'h0, irq});
        wr(LCC_OFS_IRQ_STAT, 32'h0);
        wr(LCC_OFS_DIAG, 32'h0);
        $display("test interrupts done");
        wr(LCC_OFS_CTRL, 32'h0020_0000);
        @(posedge clk_i) xcyc <= 1;
        @(posedge clk_i) xcyc <= 0;
        rc(LCC_OFS_CYC_TIMER, 32'h0000_1000, "ext_tick");
        root <= 1;
        wr(LCC_OFS_CTRL, 32'h0050_0000);
        n0 = starts;
        repeat (3080) @(posedge clk_i);
        chk("starts", 1, starts - n0);
        root <= 0;
        wr(LCC_OFS_CTRL, 32'h0);
        $display("test cycle timer done");
        report_and_stop();
    end
endmodule
`default_nettype wire
